//--- dv/spp_prog_model.sv
`timescale 1ns/1ps
`default_nettype none
// Programmer: clock idles low, data moves on the fall
module spp_prog_model (
  output logic sck_o,
  output logic sd_o,
  output logic master_clear_pin_o,
  input wire logic pin_i
);
  initial
  begin
    sck_o = 1'b0;
    sd_o = 1'b0;
    master_clear_pin_o = 1'b1;
  end
  // Released pin toggles so a stale level never passes
  task automatic sh(input logic [31:0] v, input int n, input bit msb, input bit rel,
    output logic [31:0] r);
    r = '0;
    for (int i = 0; i < n; i++)
    begin
      sd_o = rel ? ~sd_o : (msb ? v[n-1-i] : v[i]);
      #62.5 sck_o = 1'b1;
      r[i] = pin_i;
      #62.5 sck_o = 1'b0;
    end
  endtask : sh
  task automatic enter(input logic [31:0] key);
    logic [31:0] r;
    master_clear_pin_o = 1'b0;
    #500 sh(key, 32, 1'b1, 1'b0, r);
    #500 master_clear_pin_o = 1'b1;
    #500;
  endtask : enter
  task automatic exec_shift_cmd(input logic [23:0] ins);
    logic [31:0] r;
    sh(32'h0, 4, 1'b0, 1'b0, r);
    sh({8'h00, ins}, 24, 1'b0, 1'b0, r);
  endtask : exec_shift_cmd
  task automatic rdout(output logic [15:0] v);
    logic [31:0] r;
    sh(32'h1, 4, 1'b0, 1'b0, r);
    sh(32'h0, 8, 1'b0, 1'b0, r);
    sh(32'h0, 16, 1'b0, 1'b1, r);
    v = r[15:0];
  endtask : rdout
endmodule : spp_prog_model
`default_nettype wire

//--- dv/test_spp_port.sv
`timescale 1ns/1ps
`default_nettype none
module test_spp_port;
  import spp_pkg::*;
  logic clk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic sck, sd, pin, master_clear_pin, d_o, oe, mode, hiz, susp, idle, ex, frc, crst;
  logic [23:0] ins;
  logic [3:0] fcmd;
  logic [7:0] awaddr = '0, araddr = '0;
  logic [31:0] wdata = '0, rdata;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic [3:0] wstrb = 4'hF; // Byte lanes of the next write
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp;
  int errors = 0, comparisons = 0, execs = 0, forced = 0, resets = 0;
  // Flash rows: op code beside its one-hot command
  logic [14:0] fo [4] = '{OP_CHIP_ERASE, OP_PAGE_ERASE, OP_WORD_WRITE, OP_ROW_WRITE};
  logic [3:0] fc [4] = '{4'h1, 4'h2, 4'h4, 4'h8};
  always #4 clk_i = ~clk_i;
  // Device drive wins while enabled
  assign pin = oe ? d_o : sd;
  always @(posedge clk_i) execs <= execs + ex;
  always @(posedge clk_i) forced <= forced + frc;
  always @(posedge clk_i) resets <= resets + crst;
  // Word write keeps its full length; the poll below waits it out
  spp_port #(.CHIP_CYC(10), .PAGE_CYC(10), .ROW_CYC(10)) dut_u (
    .clk_i(clk_i), .rst_n_i(rst_n_i), .prog_clock_pin_i(sck), .prog_data_pin_i(pin),
    .prog_data_pin_o(d_o), .prog_data_pin_oe_o(oe), .master_clear_pin_i(master_clear_pin),
    .serial_prog_mode_o(mode), .io_hiz_o(hiz), .cpu_suspend_o(susp), .cpu_idle_o(idle),
    .instr_o(ins), .instr_exec_o(ex), .instr_forced_o(frc), .cpu_reset_o(crst),
    .flash_cmd_o(fcmd), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready));
  spp_prog_model pm (.sck_o(sck), .sd_o(sd), .master_clear_pin_o(master_clear_pin), .pin_i(pin));
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    comparisons++;
    if (g !== e)
    begin
      errors++;
      $display("unexpected at %0t: got %h exp %h", $time, g, e);
    end
  endtask : chk
  // Address and data offered together, each dropped once taken
  task automatic wr(input logic [7:0] a, input logic [31:0] v, output logic [1:0] r);
    @(posedge clk_i);
    awaddr <= a;
    wdata <= v;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do
    begin
      @(posedge clk_i);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end
    while (!bvalid);
    r = bresp;
    bready <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [31:0] v, output logic [1:0] r);
    @(posedge clk_i);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do
    begin
      @(posedge clk_i);
      if (arready) arvalid <= 1'b0;
    end
    while (!rvalid);
    v = rdata;
    r = rresp;
    rready <= 1'b0;
  endtask : rd
  task automatic wrap_up();
    $display("errors %0d comparisons %0d", errors, comparisons);
    if (errors == 0 && comparisons > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : wrap_up
  // Watchdog well past the expected run
  initial
  begin
    #400000;
    errors++;
    wrap_up();
  end
  initial
  begin
    logic [31:0] d;
    logic [1:0] r;
    logic [15:0] v;
    int k;
    repeat (3) @(posedge clk_i);
    rst_n_i <= 1'b1;
    repeat (3) @(posedge clk_i);
    rd(ADDR_FLASH_OP, d, r);
    chk(d, 0);
    rd(8'h20, d, r);
    chk(r, RESP_SLVERR);
    foreach (fo[i])
    begin
      wr(ADDR_FLASH_OP, {17'h1, fo[i]}, r);
      repeat (3) @(posedge clk_i);
      chk(fcmd, fc[i]);
      k = 0;
      do
      begin
        rd(ADDR_FLASH_OP, d, r);
        k++;
      end
      while (d[15] && k < 3000);
      chk(d, {17'h0, fo[i]});
    end
    $display("flash ops done");
    pm.enter(32'h4D434852);
    chk(mode, 0);
    pm.enter(ENTRY_KEY);
    chk({mode, hiz}, 2'b11);
    pm.sh(0, 9, 1'b0, 1'b0, d);
    chk({ins, forced[3:0], execs[3:0]}, 32'h00000011);
    pm.sh(32'h040200, 24, 1'b0, 1'b0, d);
    chk(ins, 24'h040200);
    pm.exec_shift_cmd(24'h000000);
    repeat (2) pm.exec_shift_cmd(24'h000000);
    $display("entry done");
    wr(ADDR_READOUT, 32'h5AFF, r);
    wstrb <= 4'h1;
    wr(ADDR_READOUT, 32'hFF3C, r);
    wstrb <= 4'hF;
    chk(r, RESP_OKAY);
    rd(ADDR_READOUT, d, r);
    chk(d, 32'h00005A3C);
    // Top bit low: the next command's first bit meets the still-driven pin
    pm.rdout(v);
    chk(v, 16'h5A3C);
    chk(oe, 1);
    pm.sh(32'h0, 4, 1'b0, 1'b0, d);
    chk({oe, susp}, 2'b01);
    pm.sh(32'h0, 24, 1'b0, 1'b0, d);
    chk({susp, execs[7:0]}, 9'h006);
    pm.sh(32'h2, 4, 1'b0, 1'b0, d);
    pm.exec_shift_cmd(24'h000123);
    chk({ins, execs[7:0]}, 32'h00012307);
    // Jump into the vector region from a safe address
    pm.exec_shift_cmd(24'h040100);
    chk({resets[3:0], execs[3:0]}, 8'h17);
    rd(ADDR_STATUS, d, r);
    chk(d, 32'h00000019);
    $display("serial done");
    pm.master_clear_pin_o = 1'b0;
    #500;
    chk(mode, 0);
    // Second reset in mid-run, clear back high without a key
    @(posedge clk_i);
    rst_n_i <= 1'b0;
    repeat (3) @(posedge clk_i);
    pm.master_clear_pin_o = 1'b1;
    rst_n_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    chk({mode, hiz, oe, susp}, 4'h0);
    $display("reset done");
    wrap_up();
  end
endmodule : test_spp_port
`default_nettype wire

//--- hw/spp_flash_seq.sv
`timescale 1ns/1ps
`default_nettype none
module spp_flash_seq #(
  parameter int unsigned CHIP_CYC = 1,
  parameter int unsigned PAGE_CYC = 1,
  parameter int unsigned WORD_CYC = 1,
  parameter int unsigned ROW_CYC = 1
) (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic go_i,
  input wire logic [14:0] op_i,
  output logic busy_o,
  output logic done_o,
  output logic err_o,
  output logic [3:0] cmd_o
);
  import spp_pkg::*;
  logic [31:0] cnt_r; // Cycles left in running op
  logic [31:0] len_nxt; // Duration of requested op
  logic [3:0] cmd_nxt; // One-hot op select
  ////////////////////////////////////////////////////////////
  // Decode requested operation
  always_comb
  begin
    len_nxt = 32'h00000001;
    cmd_nxt = 4'h0;
    unique case (op_i)
      OP_CHIP_ERASE:
      begin
        len_nxt = CHIP_CYC;
        cmd_nxt = 4'h1;
      end
      OP_PAGE_ERASE:
      begin
        len_nxt = PAGE_CYC;
        cmd_nxt = 4'h2;
      end
      OP_WORD_WRITE:
      begin
        len_nxt = WORD_CYC;
        cmd_nxt = 4'h4;
      end
      OP_ROW_WRITE:
      begin
        len_nxt = ROW_CYC;
        cmd_nxt = 4'h8;
      end
      default: cmd_nxt = 4'h0; // Unknown value runs one empty cycle
    endcase
  end
  ////////////////////////////////////////////////////////////
  // Self-timed run; done pulses as busy falls
  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
    begin
      busy_o <= 1'b0;
      done_o <= 1'b0;
      err_o <= 1'b0;
      cnt_r <= 32'h00000000;
      cmd_o <= 4'h0;
    end
    else
    begin
      done_o <= 1'b0;
      err_o <= 1'b0;
      if (!busy_o && go_i && !done_o)
      begin
        busy_o <= 1'b1;
        cnt_r <= len_nxt;
        cmd_o <= cmd_nxt;
        err_o <= (cmd_nxt == 4'h0);
      end
      else if (busy_o)
      begin
        if (cnt_r <= 32'h00000001)
        begin
          busy_o <= 1'b0;
          done_o <= 1'b1;
          cmd_o <= 4'h0;
        end
        cnt_r <= cnt_r - 32'h00000001;
      end
    end
  end
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);
  a_done_ends_busy: assert property (done_o |-> !busy_o && $past(busy_o))
    else $error("done without preceding busy");
  a_cmd_onehot: assert property (busy_o |-> $onehot0(cmd_o))
    else $error("flash command not one-hot");
endmodule : spp_flash_seq
`default_nettype wire

//--- hw/spp_pkg.sv
package spp_pkg;
  typedef enum logic [2:0] {SP_FORCE, SP_CMD, SP_SIX, SP_RIDLE, SP_RSHIFT} spp_state_e;
  // Serial phase lengths, last count index
  localparam logic [4:0] CNT_FORCE = 5'h08;
  localparam logic [4:0] CNT_CMD = 5'h03;
  localparam logic [4:0] CNT_SIX = 5'h17;
  localparam logic [4:0] CNT_RIDLE = 5'h07;
  localparam logic [4:0] CNT_RSHIFT = 5'h0F;
  localparam logic [3:0] CODE_EXEC = 4'h0;
  localparam logic [3:0] CODE_READ = 4'h1;
  localparam logic [31:0] ENTRY_KEY = 32'h4D434851;
  localparam logic [23:0] INSTR_NOP = 24'h000000;
  localparam logic [7:0] GOTO_OPC = 8'h04;
  // Program counter map
  localparam logic [23:0] PC_RESET = 24'h000000;
  localparam logic [23:0] PC_STEP = 24'h000002;
  localparam logic [23:0] PC_SAFE_LO = 24'h000200;
  localparam logic [23:0] CODE_LIMIT = 24'h02ABFE;
  localparam logic [23:0] EXEC_BASE = 24'h800000;
  localparam logic [23:0] EXEC_END = 24'h8007FE;
  // Flash operation codes, go bit excluded
  localparam int GO_BIT = 15;
  localparam logic [14:0] OP_CHIP_ERASE = 15'h404F;
  localparam logic [14:0] OP_PAGE_ERASE = 15'h4042;
  localparam logic [14:0] OP_WORD_WRITE = 15'h4003;
  localparam logic [14:0] OP_ROW_WRITE = 15'h4001;
  // Self-timed durations and clock period
  localparam int CLK_NS = 8;
  localparam int T_CHIP_ERASE_NS = 400000;
  localparam int T_PAGE_ERASE_NS = 200000;
  localparam int T_WORD_WRITE_NS = 40000;
  localparam int T_ROW_WRITE_NS = 200000;
  // Register map, byte addresses
  localparam logic [7:0] ADDR_FLASH_OP = 8'h00;
  localparam logic [7:0] ADDR_READOUT = 8'h04;
  localparam logic [7:0] ADDR_STATUS = 8'h08;
  localparam logic [7:0] ADDR_INSTR = 8'h0C;
  localparam logic [7:0] ADDR_PC = 8'h10;
  localparam logic [15:0] FLASH_OP_RST = 16'h0000;
  localparam logic [15:0] READOUT_RST = 16'h0000;
  // Status bit positions
  localparam int ST_MODE = 0;
  localparam int ST_BUSY = 1;
  localparam int ST_OPERR = 2;
  localparam int ST_RSVD = 3;
  localparam int ST_FAULT = 4;
  localparam int ST_STATE = 8;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage : spp_pkg

//--- hw/spp_port.sv
// Decided for this implementation: the AXI4-Lite register port and the register offsets.
`timescale 1ns/1ps
`default_nettype none
module spp_port #(
  parameter int unsigned CHIP_CYC = spp_pkg::T_CHIP_ERASE_NS / spp_pkg::CLK_NS,
  parameter int unsigned PAGE_CYC = spp_pkg::T_PAGE_ERASE_NS / spp_pkg::CLK_NS,
  parameter int unsigned WORD_CYC = spp_pkg::T_WORD_WRITE_NS / spp_pkg::CLK_NS,
  parameter int unsigned ROW_CYC = spp_pkg::T_ROW_WRITE_NS / spp_pkg::CLK_NS
) (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic prog_clock_pin_i,
  input wire logic prog_data_pin_i,
  output logic prog_data_pin_o,
  output logic prog_data_pin_oe_o,
  input wire logic master_clear_pin_i,
  output logic serial_prog_mode_o,
  output logic io_hiz_o,
  output logic cpu_suspend_o,
  output logic cpu_idle_o,
  output logic [23:0] instr_o,
  output logic instr_exec_o,
  output logic instr_forced_o,
  output logic cpu_reset_o,
  output logic [3:0] flash_cmd_o,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  import spp_pkg::*;
  ////////////////////////////////////////////////////////////
  // Declarations
  logic [2:0] clk_sy_r; // Serial clock sync plus edge history
  logic [1:0] dat_sy_r; // Data pin synchroniser
  logic [2:0] master_clear_pin_sy_r; // Clear pin sync plus history
  logic rise, fall; // Serial clock edges in clk_i domain
  logic din; // Synchronised data bit
  logic master_clear_pin_s, master_clear_pin_rise;
  logic [31:0] key_r; // Entry key, MSB first
  logic mode_r; // Programming mode active
  spp_state_e state_r, state_nxt;
  logic [4:0] cnt_r, cnt_nxt; // Rising edges within phase
  logic [23:0] sh_r; // LSB-first shifter, fills from top
  logic [3:0] code; // Command as of fourth bit
  logic [23:0] word; // Instruction as of 24th bit
  logic exec_nxt, forced_nxt, hold_r;
  logic [15:0] ro_latch_r; // Readout value frozen for shift
  logic [23:0] pc_r, pc_nxt;
  logic pc_bad_nxt, pc_bad_cur, fault;
  logic [15:0] flash_op_r, readout_r;
  logic op_err_r, rsvd_r, fault_r;
  logic fl_busy, fl_done, fl_err;
  logic [7:0] aw_addr_r;
  logic [31:0] w_data_r;
  logic [3:0] w_strb_r;
  logic aw_have_r, w_have_r, wr_fire;
  logic [31:0] rd_mux;
  logic rd_hit;
  ////////////////////////////////////////////////////////////
  // Pin synchronisers; only stage two and later are read
  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
    begin
      clk_sy_r <= 3'h0;
      dat_sy_r <= 2'h0;
      master_clear_pin_sy_r <= 3'h0;
    end
    else
    begin
      clk_sy_r <= {clk_sy_r[1:0], prog_clock_pin_i};
      dat_sy_r <= {dat_sy_r[0], prog_data_pin_i};
      master_clear_pin_sy_r <= {master_clear_pin_sy_r[1:0], master_clear_pin_i};
    end
  end
  // Edges: clk_i must run well above the serial clock
  assign rise = clk_sy_r[1] && !clk_sy_r[2];
  assign fall = !clk_sy_r[1] && clk_sy_r[2];
  assign din = dat_sy_r[1];
  assign master_clear_pin_s = master_clear_pin_sy_r[1];
  assign master_clear_pin_rise = master_clear_pin_sy_r[1] && !master_clear_pin_sy_r[2];
  ////////////////////////////////////////////////////////////
  // Key capture while clear is low, then mode gate
  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
    begin
      key_r <= 32'h00000000;
      mode_r <= 1'b0;
    end
    else if (!master_clear_pin_s)
    begin
      mode_r <= 1'b0;
      if (rise)
        key_r <= {key_r[30:0], din};
    end
    else if (master_clear_pin_rise)
    begin
      mode_r <= (key_r == ENTRY_KEY);
      key_r <= 32'h00000000; // Stale key never reused
    end
  end
  ////////////////////////////////////////////////////////////
  // Command sequencer, advanced on serial rising edges
  assign code = {din, sh_r[23:21]};
  assign word = {din, sh_r[23:1]};
  always_comb
  begin
    state_nxt = state_r;
    cnt_nxt = cnt_r;
    exec_nxt = 1'b0;
    forced_nxt = 1'b0;
    if (!mode_r || fault)
    begin
      state_nxt = SP_FORCE;
      cnt_nxt = 5'h00;
    end
    else if (rise)
    begin
      cnt_nxt = cnt_r + 5'h01;
      unique case (state_r)
        SP_FORCE:
          if (cnt_r == CNT_FORCE)
          begin
            // Nine clocks regardless of data, NOP runs
            state_nxt = SP_SIX;
            cnt_nxt = 5'h00;
            exec_nxt = 1'b1;
            forced_nxt = 1'b1;
          end
        SP_CMD:
          if (cnt_r == CNT_CMD)
          begin
            cnt_nxt = 5'h00;
            if (code == CODE_EXEC)
              state_nxt = SP_SIX;
            else if (code == CODE_READ)
              state_nxt = SP_RIDLE;
            else
              state_nxt = SP_CMD; // Reserved codes are dropped
          end
        SP_SIX:
          if (cnt_r == CNT_SIX)
          begin
            // Word complete; executes during next command
            state_nxt = SP_CMD;
            cnt_nxt = 5'h00;
            exec_nxt = 1'b1;
          end
        SP_RIDLE:
          if (cnt_r == CNT_RIDLE)
          begin
            state_nxt = SP_RSHIFT;
            cnt_nxt = 5'h00;
          end
        SP_RSHIFT:
          if (cnt_r == CNT_RSHIFT)
          begin
            state_nxt = SP_CMD;
            cnt_nxt = 5'h00;
          end
      endcase
    end
  end
  // State, shifter and CPU-facing flags
  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
    begin
      state_r <= SP_FORCE;
      cnt_r <= 5'h00;
      sh_r <= 24'h000000;
      cpu_suspend_o <= 1'b0;
      cpu_idle_o <= 1'b0;
      instr_exec_o <= 1'b0;
      instr_forced_o <= 1'b0;
      instr_o <= INSTR_NOP;
    end
    else
    begin
      state_r <= state_nxt;
      cnt_r <= cnt_nxt;
      if (rise)
        sh_r <= {din, sh_r[23:1]};
      cpu_suspend_o <= (state_nxt == SP_SIX);
      cpu_idle_o <= (state_nxt == SP_RIDLE);
      instr_exec_o <= exec_nxt;
      instr_forced_o <= forced_nxt;
      if (exec_nxt)
        instr_o <= forced_nxt ? INSTR_NOP : word;
    end
  end
  ////////////////////////////////////////////////////////////
  // Readout drive: change on fall, release on next rise
  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
    begin
      prog_data_pin_o <= 1'b0;
      prog_data_pin_oe_o <= 1'b0;
      hold_r <= 1'b0;
      ro_latch_r <= READOUT_RST;
    end
    else if (!mode_r || fault)
    begin
      prog_data_pin_oe_o <= 1'b0;
      hold_r <= 1'b0;
    end
    else
    begin
      if (rise && state_r == SP_RIDLE && cnt_r == CNT_RIDLE)
        ro_latch_r <= readout_r;
      if (fall && state_r == SP_RSHIFT)
      begin
        prog_data_pin_o <= ro_latch_r[cnt_r[3:0]];
        prog_data_pin_oe_o <= 1'b1;
      end
      if (rise && state_r == SP_RSHIFT && cnt_r == CNT_RSHIFT)
        hold_r <= 1'b1;
      else if (rise && hold_r)
      begin
        hold_r <= 1'b0;
        prog_data_pin_oe_o <= 1'b0;
      end
    end
  end
  ////////////////////////////////////////////////////////////
  // Program counter; no stall logic, hazards are host's job
  function automatic logic pc_bad(input logic [23:0] pc);
    pc_bad = (pc < PC_SAFE_LO) || (pc > CODE_LIMIT && pc < EXEC_BASE) || (pc > EXEC_END);
  endfunction : pc_bad
  always_comb
  begin
    pc_nxt = pc_r + PC_STEP;
    if (word[23:16] == GOTO_OPC)
      pc_nxt = {8'h00, word[15:1], 1'b0}; // Low half of jump target
  end
  assign pc_bad_nxt = pc_bad(pc_nxt);
  assign pc_bad_cur = pc_bad(pc_r);
  // Fault only on moving from a safe address into a bad one
  assign fault = rise && state_r == SP_SIX && cnt_r == CNT_SIX && pc_bad_nxt && !pc_bad_cur;
  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
    begin
      pc_r <= PC_RESET;
      cpu_reset_o <= 1'b0;
    end
    else
    begin
      cpu_reset_o <= fault;
      if (!mode_r || fault)
        pc_r <= PC_RESET;
      else if (exec_nxt && !forced_nxt)
        pc_r <= pc_nxt;
    end
  end
  // Mode drives unused pins off chip
  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
    begin
      serial_prog_mode_o <= 1'b0;
      io_hiz_o <= 1'b0;
    end
    else
    begin
      serial_prog_mode_o <= mode_r;
      io_hiz_o <= mode_r;
    end
  end
  ////////////////////////////////////////////////////////////
  // Flash sequencer
  spp_flash_seq #(
    .CHIP_CYC(CHIP_CYC),
    .PAGE_CYC(PAGE_CYC),
    .WORD_CYC(WORD_CYC),
    .ROW_CYC(ROW_CYC)
  ) u_flash (
    .clk_i(clk_i),
    .rst_n_i(rst_n_i),
    .go_i(flash_op_r[GO_BIT]),
    .op_i(flash_op_r[14:0]),
    .busy_o(fl_busy),
    .done_o(fl_done),
    .err_o(fl_err),
    .cmd_o(flash_cmd_o)
  );
  ////////////////////////////////////////////////////////////
  // AXI4-Lite write channel; address and data in any order
  assign wr_fire = aw_have_r && w_have_r && !s_axi_bvalid;
  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
    begin
      aw_have_r <= 1'b0;
      w_have_r <= 1'b0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
      aw_addr_r <= 8'h00;
      w_data_r <= 32'h00000000;
      w_strb_r <= 4'h0;
    end
    else
    begin
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_have_r <= 1'b1;
        aw_addr_r <= s_axi_awaddr;
        s_axi_awready <= 1'b0;
      end
      else if (!aw_have_r || wr_fire)
      begin
        aw_have_r <= 1'b0;
        s_axi_awready <= 1'b1;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_have_r <= 1'b1;
        w_data_r <= s_axi_wdata;
        w_strb_r <= s_axi_wstrb;
        s_axi_wready <= 1'b0;
      end
      else if (!w_have_r || wr_fire)
      begin
        w_have_r <= 1'b0;
        s_axi_wready <= 1'b1;
      end
      if (wr_fire)
      begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= (aw_addr_r == ADDR_FLASH_OP || aw_addr_r == ADDR_READOUT ||
                        aw_addr_r == ADDR_STATUS) ? RESP_OKAY : RESP_SLVERR;
      end
      else if (s_axi_bready)
        s_axi_bvalid <= 1'b0;
    end
  end
  // Register updates; hardware set beats software clear
  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
    begin
      flash_op_r <= FLASH_OP_RST;
      readout_r <= READOUT_RST;
      op_err_r <= 1'b0;
      rsvd_r <= 1'b0;
      fault_r <= 1'b0;
    end
    else
    begin
      if (wr_fire && aw_addr_r == ADDR_FLASH_OP && w_strb_r[0])
        flash_op_r[7:0] <= w_data_r[7:0];
      if (wr_fire && aw_addr_r == ADDR_FLASH_OP && w_strb_r[1])
        flash_op_r[14:8] <= w_data_r[14:8];
      if (wr_fire && aw_addr_r == ADDR_FLASH_OP && w_strb_r[1] && w_data_r[GO_BIT])
        flash_op_r[GO_BIT] <= 1'b1;
      else if (fl_done)
        flash_op_r[GO_BIT] <= 1'b0;
      if (wr_fire && aw_addr_r == ADDR_READOUT && w_strb_r[0])
        readout_r[7:0] <= w_data_r[7:0];
      if (wr_fire && aw_addr_r == ADDR_READOUT && w_strb_r[1])
        readout_r[15:8] <= w_data_r[15:8];
      // Sticky flags, write one to clear
      if (fl_err)
        op_err_r <= 1'b1;
      else if (wr_fire && aw_addr_r == ADDR_STATUS && w_strb_r[0] && w_data_r[ST_OPERR])
        op_err_r <= 1'b0;
      if (rise && state_r == SP_CMD && cnt_r == CNT_CMD && code > CODE_READ)
        rsvd_r <= 1'b1;
      else if (wr_fire && aw_addr_r == ADDR_STATUS && w_strb_r[0] && w_data_r[ST_RSVD])
        rsvd_r <= 1'b0;
      if (fault)
        fault_r <= 1'b1;
      else if (wr_fire && aw_addr_r == ADDR_STATUS && w_strb_r[0] && w_data_r[ST_FAULT])
        fault_r <= 1'b0;
    end
  end
  ////////////////////////////////////////////////////////////
  // AXI4-Lite read channel, one cycle latency
  always_comb
  begin
    rd_mux = 32'h00000000;
    rd_hit = 1'b1;
    unique case (s_axi_araddr)
      ADDR_FLASH_OP: rd_mux = {16'h0000, flash_op_r};
      ADDR_READOUT: rd_mux = {16'h0000, readout_r};
      ADDR_STATUS:
      begin
        rd_mux[ST_MODE] = mode_r;
        rd_mux[ST_BUSY] = fl_busy;
        rd_mux[ST_OPERR] = op_err_r;
        rd_mux[ST_RSVD] = rsvd_r;
        rd_mux[ST_FAULT] = fault_r;
        rd_mux[ST_STATE +: 3] = state_r;
      end
      ADDR_INSTR: rd_mux = {8'h00, instr_o};
      ADDR_PC: rd_mux = {8'h00, pc_r};
      default: rd_hit = 1'b0; // Unmapped reads zero, error
    endcase
  end
  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= RESP_OKAY;
    end
    else if (s_axi_arvalid && s_axi_arready)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= rd_mux;
      s_axi_rresp <= rd_hit ? RESP_OKAY : RESP_SLVERR;
    end
    else if (s_axi_rvalid && s_axi_rready)
    begin
      s_axi_rvalid <= 1'b0;
      s_axi_arready <= 1'b1;
    end
    else if (!s_axi_rvalid)
      s_axi_arready <= 1'b1;
  end
  ////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);
  sequence s_last_read_bit;
    rise && state_r == SP_RSHIFT && cnt_r == CNT_RSHIFT && mode_r && !fault;
  endsequence
  // Exec pulse and word land one cycle after the 24th rise
  a_six_exec: assert property (rise && mode_r && state_r == SP_SIX
                               && cnt_r == CNT_SIX && !fault
                               |=> instr_exec_o && instr_o == $past(word))
    else $error("instruction not issued after 24 bits");
  a_exec_with_cmd: assert property (instr_exec_o && !instr_forced_o |-> state_r == SP_CMD)
    else $error("execute not overlapped with command");
  a_force_nine: assert property (state_r == SP_FORCE && state_nxt == SP_SIX |-> cnt_r == CNT_FORCE)
    else $error("forced command left early");
  a_read_decode: assert property (rise && mode_r && !fault && state_r == SP_CMD
                                  && cnt_r == CNT_CMD && code == CODE_READ
                                  |=> state_r == SP_RIDLE ##1 cpu_idle_o)
    else $error("readout code not decoded");
  a_oe_in_shift: assert property (fall && mode_r && state_r == SP_RSHIFT |=> prog_data_pin_oe_o)
    else $error("data pin not driven during readout");
  a_oe_release: assert property (s_last_read_bit |=> prog_data_pin_oe_o && hold_r)
    else $error("drive dropped before next rising edge");
  a_oe_cmd_off: assert property (rise && hold_r && mode_r && state_r == SP_CMD
                                 |=> !prog_data_pin_oe_o)
    else $error("data pin not released");
  a_key_gate: assert property ($rose(mode_r) |-> $past(key_r) == ENTRY_KEY)
    else $error("mode entered without key");
  a_clear_abort: assert property (!master_clear_pin_s |=> !mode_r ##1 state_r == SP_FORCE)
    else $error("clear low did not abort");
  a_pc_fault: assert property (fault |=> cpu_reset_o && state_r == SP_FORCE)
    else $error("bad pc did not reset");
  a_hiz_mode: assert property (mode_r |=> io_hiz_o)
    else $error("pins not released in mode");
  a_go_clear: assert property (fl_done && !(wr_fire && aw_addr_r == ADDR_FLASH_OP)
                               |=> !flash_op_r[GO_BIT])
    else $error("go bit not cleared at end");
endmodule : spp_port
`default_nettype wire
